// ---- design/tw_pkg.sv ----
// Purpose: shared constants for the thermal wire host configuration block
// Assumes: 8-bit index-addressed register bank, 100 MHz system clock
// Notes: all offsets, reset values, field positions and timings live here
package tw_pkg;
  // register indexes
  localparam logic [7:0] REG_FUNC = 8'h01;
  localparam logic [7:0] REG_TIMING = 8'h02;
  localparam logic [7:0] REG_AGENT = 8'h03;
  localparam logic [7:0] REG_TEMPCFG = 8'h04;
  localparam logic [7:0] REG_RAW_FIRST = 8'h17;
  localparam logic [7:0] REG_RAW_LAST = 8'h1e;
  localparam logic [7:0] REG_READ0 = 8'h20;
  localparam logic [7:0] REG_READ1 = 8'h21;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  // reset values
  localparam logic [7:0] FUNC_RST = 8'h14;
  localparam logic [7:0] TIMING_RST = 8'h02;
  localparam logic [7:0] AGENT_RST = 8'h00;
  localparam logic [7:0] TEMPCFG_RST = 8'h00;
  localparam logic [15:0] RAW_RST = 16'h8001;
  localparam logic [7:0] READ_RST = 8'h00;
  // field positions
  localparam int FUNC_EN_BIT = 7;
  localparam int V3_BIT = 2;
  localparam int MANUAL_BIT = 1;
  localparam int ROUTINE_BIT = 0;
  localparam int RATE_LSB = 4;
  localparam int ADJ_LSB = 1;
  localparam int DUTY_BIT = 0;
  localparam int AGT_EN_LSB = 4;
  localparam int DOM1_AGT0_BIT = 0;
  localparam int DOM1_AGT1_BIT = 1;
  localparam int VIRT_BIT = 7;
  localparam int CLAMP_BIT = 4;
  localparam int DSEL_LSB = 1;
  localparam int HIGHER_BIT = 0;
  // agent enable codes
  localparam logic [1:0] AGT_EN_A0 = 2'b01;
  localparam logic [1:0] AGT_EN_BOTH = 2'b11;
  // raw data codes
  localparam logic [15:0] ERR_FIRST = 16'h8000;
  localparam logic [15:0] ERR_UNDER = 16'h8002;
  localparam logic [15:0] ERR_OVER = 16'h8003;
  localparam logic [15:0] ERR_LAST = 16'h81ff;
  localparam logic [7:0] TEMP_UNDER_VAL = 8'h00;
  localparam logic [7:0] TEMP_OVER_VAL = 8'h7f;
  localparam logic signed [9:0] CLAMP_HIGH = 10'sh000;
  localparam logic signed [9:0] CLAMP_LOW = -10'sh080;
  // wire timing
  localparam int CLK_KHZ = 100000;
  localparam int BASE_RATE_KHZ = 1500;
  localparam int BIT_CYC = CLK_KHZ / BASE_RATE_KHZ;
  localparam int DONE_LEAD = 3;
  localparam int DUTY_HI_PCT = 75;
  localparam int DUTY_LO_PCT = 68;
  localparam int PCT = 100;
  localparam int CNT_W = 10;
  localparam int ROUTINE_US = 1000;
  localparam int ROUTINE_CYC = ROUTINE_US * (CLK_KHZ / 1000);
  // frame layout
  localparam logic [7:0] ADDR_BASE = 8'h30;
  localparam logic [7:0] CMD_GETTEMP = 8'h01;
  localparam logic [7:0] CMD_GETTEMP_DOM = 8'h02;
  localparam logic [4:0] TX_LAST = 5'h0f;
  localparam logic [4:0] RX_LAST = 5'h0f;
  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} tw_state_t;
endpackage

// ---- design/tw_bit_timer.sv ----
// Purpose: one bit time on the thermal wire, host side
// Assumes: wire_in_s already synchronised to clk
// Notes: outputs lag the bit counter by one cycle, harmless at these rates
`timescale 1ns/1ps
module tw_bit_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic tx_mode,
  input wire logic tx_bit,
  input wire logic [1:0] rate_sel,
  input wire logic [2:0] adj,
  input wire logic duty_sel,
  // wire side
  input wire logic wire_in_s,
  output logic wire_out,
  output logic wire_oe_n,
  // results
  output logic done,
  output logic rx_bit
);
  localparam int CW = tw_pkg::CNT_W;
  logic busy;
  logic rx_q;
  logic [CW-1:0] cnt;
  logic [CW-1:0] period_q;
  logic [CW-1:0] hi_q;
  logic [CW-1:0] per;
  logic [15:0] scaled;
  logic [CW-1:0] hi1;
  logic [CW-1:0] hi0;

  assign per = CW'(tw_pkg::BIT_CYC) << rate_sel;
  assign scaled = (16'(per) * (duty_sel ? 16'(tw_pkg::DUTY_LO_PCT) :
                  16'(tw_pkg::DUTY_HI_PCT))) / 16'(tw_pkg::PCT);
  // slow rising edges eat into the high time, so stretch it
  assign hi1 = CW'(scaled) + CW'(adj);
  assign hi0 = CW'(per >> 2) + CW'(adj);

  always_ff @(posedge clk) begin
    if (!rst_n || abort) begin
      busy <= 1'b0;
      cnt <= '0;
      period_q <= '0;
      hi_q <= '0;
      rx_q <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      cnt <= '0;
      period_q <= per;
      hi_q <= (tx_mode && tx_bit) ? hi1 : hi0;
      rx_q <= !tx_mode;
    end else if (busy) begin
      cnt <= cnt + CW'(1);
      if (cnt == period_q - CW'(1)) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || abort) begin
      done <= 1'b0;
      rx_bit <= 1'b0;
      wire_out <= 1'b0;
      wire_oe_n <= 1'b1;
    end else begin
      // done leads the end so the next start lands on the period edge
      done <= busy && (cnt == period_q - CW'(tw_pkg::DONE_LEAD));
      if (busy && rx_q && (cnt == (period_q >> 1))) begin
        rx_bit <= wire_in_s;
      end
      wire_out <= busy && (cnt < hi_q);
      // on receive the client owns the wire after the host's short high
      wire_oe_n <= !(busy && (!rx_q || (cnt < hi_q)));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rate_slowest: assert property (start && !abort && rate_sel == 2'b11
    |=> period_q == 10'd528) else $error("slowest rate period wrong");
  a_adj_stretch: assert property (start && !abort && !tx_mode
    && rate_sel == 2'b00 |=> hi_q == 10'd16 + 10'($past(adj)))
    else $error("edge stretch wrong");
  a_duty_high: assert property (start && !abort && tx_mode && tx_bit
    && rate_sel == 2'b00 && adj == 3'd1
    |=> hi_q == ($past(duty_sel) ? 10'd45 : 10'd50))
    else $error("duty high time wrong");
endmodule

// ---- design/tw_host_cfg.sv ----
// Purpose: thermal wire host: configuration bank, query engine, readings
// Assumes: 8-bit index bus with one-cycle write and read strobes
// Notes: raw values and processed readings are held in this module
`timescale 1ns/1ps
// Behaviour
// - no wire transactions unless the master function enable bit is set.
// - version-three command enable bit exists and resets to one.
// - manual bit launches one query round, then clears itself once taken.
// - routine enable runs query rounds periodically without software.
// - two-bit rate field picks 1.5 MHz, 750, 375 or 187.5 kHz.
// - three-bit adjust stretches host high time for slow edges, resets 001.
// - duty bit picks 75% (zero) or 68% (one) high time for a transmitted one bit.
// - agent enable 00 none, 01 agent 0, 11 both, 10 reserved.
// - agent-1 domain bit adds a second domain for agent 1 while the version-three bit is set.
// - agent-0 domain bit adds a second domain for agent 0 while the version-three bit is set.
// - virtual enable lets the bus write raw temperatures instead of wire.
// - clamp bit clamps positive or below -128 readings.
// - per-agent select bit picks domain 0 or domain 1 for the reading.
// - return-higher bit reports the hotter of an agent's two domains.
// - raw temperature registers reset to the sensor-missing code.
// - under and over codes set readings to 00 and 7f; other error codes update only raw registers, readings hold.
module tw_host_cfg #(
  parameter int ROUTINE_CYCLES = tw_pkg::ROUTINE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bank
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // thermal wire
  input wire logic wire_in,
  output logic wire_out,
  output logic wire_oe_n,
  // processed readings
  output logic [7:0] temp_agent0,
  output logic [7:0] temp_agent1
);
  logic [7:0] func;
  logic [7:0] timing;
  logic [7:0] agent_cfg;
  logic [7:0] temp_cfg;
  logic [15:0] raw [4];
  logic [7:0] reading [2];
  logic [15:0] sel_raw [2];
  logic in_s1;
  logic in_s2;
  tw_pkg::tw_state_t state;
  logic [1:0] cur_slot;
  logic [3:0] round_mask;
  logic [3:0] slot_en;
  logic [3:0] live_mask;
  logic [1:0] pick;
  logic [15:0] tx_shift;
  logic [15:0] rx_shift;
  logic [4:0] bit_cnt;
  logic [31:0] routine_cnt;
  logic routine_tick;
  logic bt_start;
  logic bt_tx_mode;
  logic bt_done;
  logic bt_rx_bit;
  logic en;
  logic idle_free;
  logic manual_take;
  logic routine_take;
  logic pick_take;
  logic rx_store;
  logic raw_wr;
  logic [2:0] raw_idx;
  logic a0_on;
  logic a1_on;

  function automatic logic is_err(input logic [15:0] v);
    return (v >= tw_pkg::ERR_FIRST) && (v <= tw_pkg::ERR_LAST);
  endfunction

  // normal readings beat errors; between errors the larger code wins
  function automatic logic [15:0] hotter(input logic [15:0] a,
                                         input logic [15:0] b);
    if (is_err(a) && !is_err(b)) return b;
    if (!is_err(a) && is_err(b)) return a;
    if (is_err(a)) return (a >= b) ? a : b;
    return ($signed(a) >= $signed(b)) ? a : b;
  endfunction

  assign en = func[tw_pkg::FUNC_EN_BIT];
  assign a0_on = (agent_cfg[tw_pkg::AGT_EN_LSB +: 2] == tw_pkg::AGT_EN_A0)
    || (agent_cfg[tw_pkg::AGT_EN_LSB +: 2] == tw_pkg::AGT_EN_BOTH);
  assign a1_on = agent_cfg[tw_pkg::AGT_EN_LSB +: 2] == tw_pkg::AGT_EN_BOTH;
  // second domain needs the domain-aware command
  assign slot_en = {a1_on && agent_cfg[tw_pkg::DOM1_AGT1_BIT]
                    && func[tw_pkg::V3_BIT], a1_on,
                    a0_on && agent_cfg[tw_pkg::DOM1_AGT0_BIT]
                    && func[tw_pkg::V3_BIT], a0_on};
  assign live_mask = round_mask & slot_en;
  assign pick = live_mask[0] ? 2'd0 : live_mask[1] ? 2'd1 :
                live_mask[2] ? 2'd2 : 2'd3;
  assign idle_free = en && (state == tw_pkg::ST_IDLE) && (round_mask == 4'h0);
  assign manual_take = idle_free && func[tw_pkg::MANUAL_BIT];
  assign routine_take = idle_free && routine_tick
    && func[tw_pkg::ROUTINE_BIT] && !manual_take;
  assign pick_take = en && (state == tw_pkg::ST_IDLE) && (live_mask != 4'h0);
  assign rx_store = (state == tw_pkg::ST_RX) && bt_done
    && (bit_cnt == tw_pkg::RX_LAST);
  assign raw_wr = reg_wr_en && temp_cfg[tw_pkg::VIRT_BIT]
    && (reg_addr >= tw_pkg::REG_RAW_FIRST)
    && (reg_addr <= tw_pkg::REG_RAW_LAST);
  assign raw_idx = 3'(reg_addr - tw_pkg::REG_RAW_FIRST);

  // pin synchroniser
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      in_s1 <= 1'b0;
      in_s2 <= 1'b0;
    end else begin
      in_s1 <= wire_in;
      in_s2 <= in_s1;
    end
  end

  // function register; a software write wins over the one-shot clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      func <= tw_pkg::FUNC_RST;
    end else if (reg_wr_en && reg_addr == tw_pkg::REG_FUNC) begin
      func <= reg_wdata;
    end else if (manual_take) begin
      func[tw_pkg::MANUAL_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timing <= tw_pkg::TIMING_RST;
      agent_cfg <= tw_pkg::AGENT_RST;
      temp_cfg <= tw_pkg::TEMPCFG_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == tw_pkg::REG_TIMING) timing <= reg_wdata;
      if (reg_addr == tw_pkg::REG_AGENT) agent_cfg <= reg_wdata;
      if (reg_addr == tw_pkg::REG_TEMPCFG) temp_cfg <= reg_wdata;
    end
  end

  // routine period; a tick while a round runs is dropped
  always_ff @(posedge clk) begin
    if (!rst_n || !en || !func[tw_pkg::ROUTINE_BIT]) begin
      routine_cnt <= '0;
      routine_tick <= 1'b0;
    end else if (routine_cnt == 32'(ROUTINE_CYCLES - 1)) begin
      routine_cnt <= '0;
      routine_tick <= 1'b1;
    end else begin
      routine_cnt <= routine_cnt + 32'd1;
      routine_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      round_mask <= 4'h0;
    end else if (manual_take || routine_take) begin
      round_mask <= slot_en;
    end else if (pick_take) begin
      round_mask[pick] <= 1'b0;
    end else begin
      round_mask <= round_mask & slot_en;
    end
  end

  // frame engine: 16 bits out, 16 bits back, one slot per frame
  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      state <= tw_pkg::ST_IDLE;
      cur_slot <= 2'd0;
      tx_shift <= '0;
      rx_shift <= '0;
      bit_cnt <= '0;
      bt_start <= 1'b0;
      bt_tx_mode <= 1'b0;
    end else begin
      bt_start <= 1'b0;
      case (state)
        tw_pkg::ST_IDLE: begin
          if (pick_take) begin
            cur_slot <= pick;
            tx_shift <= {tw_pkg::ADDR_BASE + {7'h00, pick[1]},
                         pick[0] ? tw_pkg::CMD_GETTEMP_DOM :
                         tw_pkg::CMD_GETTEMP};
            bit_cnt <= '0;
            bt_start <= 1'b1;
            bt_tx_mode <= 1'b1;
            state <= tw_pkg::ST_TX;
          end
        end
        tw_pkg::ST_TX: begin
          if (bt_done) begin
            bt_start <= 1'b1;
            if (bit_cnt == tw_pkg::TX_LAST) begin
              bit_cnt <= '0;
              bt_tx_mode <= 1'b0;
              state <= tw_pkg::ST_RX;
            end else begin
              bit_cnt <= bit_cnt + 5'd1;
              tx_shift <= {tx_shift[14:0], 1'b0};
            end
          end
        end
        tw_pkg::ST_RX: begin
          if (bt_done) begin
            rx_shift <= {rx_shift[14:0], bt_rx_bit};
            bit_cnt <= bit_cnt + 5'd1;
            if (bit_cnt == tw_pkg::RX_LAST) begin
              state <= tw_pkg::ST_IDLE;
            end else begin
              bt_start <= 1'b1;
            end
          end
        end
        default: state <= tw_pkg::ST_IDLE;
      endcase
    end
  end

  tw_bit_timer u_bit (
    .clk(clk),
    .rst_n(rst_n),
    .start(bt_start),
    .abort(!en),
    .tx_mode(bt_tx_mode),
    .tx_bit(tx_shift[15]),
    .rate_sel(timing[tw_pkg::RATE_LSB +: 2]),
    .adj(timing[tw_pkg::ADJ_LSB +: 3]),
    .duty_sel(timing[tw_pkg::DUTY_BIT]),
    .wire_in_s(in_s2),
    .wire_out(wire_out),
    .wire_oe_n(wire_oe_n),
    .done(bt_done),
    .rx_bit(bt_rx_bit)
  );

  // raw store: bus writes replace wire data while virtual mode is on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) raw[i] <= tw_pkg::RAW_RST;
    end else if (raw_wr) begin
      if (raw_idx[0]) raw[raw_idx[2:1]][7:0] <= reg_wdata;
      else raw[raw_idx[2:1]][15:8] <= reg_wdata;
    end else if (rx_store && !temp_cfg[tw_pkg::VIRT_BIT]) begin
      raw[cur_slot] <= {rx_shift[14:0], bt_rx_bit};
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_agent
    logic signed [9:0] t;
    assign sel_raw[g] = temp_cfg[tw_pkg::HIGHER_BIT] ?
      hotter(raw[2*g], raw[2*g+1]) :
      (temp_cfg[tw_pkg::DSEL_LSB + g] ? raw[2*g+1] : raw[2*g]);
    assign t = $signed(sel_raw[g][15:6]);
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        reading[g] <= tw_pkg::READ_RST;
      end else if (sel_raw[g] == tw_pkg::ERR_UNDER) begin
        reading[g] <= tw_pkg::TEMP_UNDER_VAL;
      end else if (sel_raw[g] == tw_pkg::ERR_OVER) begin
        reading[g] <= tw_pkg::TEMP_OVER_VAL;
      end else if (!is_err(sel_raw[g])) begin
        if (temp_cfg[tw_pkg::CLAMP_BIT] && t > tw_pkg::CLAMP_HIGH)
          reading[g] <= 8'(tw_pkg::CLAMP_HIGH);
        else if (temp_cfg[tw_pkg::CLAMP_BIT] && t < tw_pkg::CLAMP_LOW)
          reading[g] <= 8'(tw_pkg::CLAMP_LOW);
        else
          reading[g] <= t[7:0];
      end
    end
  end

  assign temp_agent0 = reading[0];
  assign temp_agent1 = reading[1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= tw_pkg::RDATA_NONE;
    end else if (reg_rd_en) begin
      case (reg_addr)
        tw_pkg::REG_FUNC: reg_rdata <= func;
        tw_pkg::REG_TIMING: reg_rdata <= timing;
        tw_pkg::REG_AGENT: reg_rdata <= agent_cfg;
        tw_pkg::REG_TEMPCFG: reg_rdata <= temp_cfg;
        tw_pkg::REG_READ0: reg_rdata <= reading[0];
        tw_pkg::REG_READ1: reg_rdata <= reading[1];
        default: begin
          if (reg_addr >= tw_pkg::REG_RAW_FIRST
              && reg_addr <= tw_pkg::REG_RAW_LAST)
            reg_rdata <= raw_idx[0] ? raw[raw_idx[2:1]][7:0] :
                         raw[raw_idx[2:1]][15:8];
          else
            reg_rdata <= tw_pkg::RDATA_NONE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_start_needs_en: assert property (bt_start |-> $past(en))
    else $error("bit started while disabled");
  a_v3_reset: assert property ($past(!rst_n) |-> func[tw_pkg::V3_BIT]
    && func == tw_pkg::FUNC_RST)
    else $error("function register reset wrong");
  a_manual_clear: assert property (manual_take && !reg_wr_en
    |=> !func[1] && round_mask == $past(slot_en))
    else $error("manual one-shot not taken");
  a_routine_round: assert property (routine_take |=> round_mask != 4'h0
    || $past(slot_en) == 4'h0) else $error("routine round lost");
  a_agent_decode: assert property (agent_cfg[5:4] == 2'b10
    |-> slot_en == 4'h0) else $error("reserved agent code queried");
  a_slot_enabled: assert property (pick_take |-> slot_en[pick]
    ##1 state == tw_pkg::ST_TX && bt_start)
    else $error("disabled slot queried");
  a_dom1_agent1: assert property (pick_take && pick == 2'd3
    |-> agent_cfg[1]) else $error("agent 1 domain 1 not enabled");
  a_dom1_agent0: assert property (pick_take && pick == 2'd1
    |-> agent_cfg[0]) else $error("agent 0 domain 1 not enabled");
  a_virtual_write: assert property (raw_wr && !raw_idx[0]
    |=> raw[$past(raw_idx[2:1])][15:8] == $past(reg_wdata))
    else $error("virtual raw write lost");
  a_clamp_pos: assert property (temp_cfg[4] && !is_err(sel_raw[0])
    && !sel_raw[0][15] && sel_raw[0][14:6] != 9'h000
    |=> reading[0] == 8'h00) else $error("positive not clamped");
  a_domain_sel: assert property (!temp_cfg[0] && temp_cfg[1]
    && !temp_cfg[4] && !is_err(raw[1])
    |=> reading[0] == $past(raw[1][13:6]))
    else $error("domain select ignored");
  a_higher_pick: assert property (temp_cfg[0] && !is_err(raw[0])
    && is_err(raw[1]) |-> sel_raw[0] == raw[0])
    else $error("normal reading not preferred");
  a_raw_reset: assert property ($past(!rst_n) |-> raw[3] == tw_pkg::RAW_RST)
    else $error("raw reset value wrong");
  a_error_hold: assert property (is_err(sel_raw[1])
    && sel_raw[1] != 16'h8002 && sel_raw[1] != 16'h8003
    |=> $stable(reading[1])) else $error("reading changed on error");
  c_manual: cover property (manual_take ##[1:4] bt_start);
  c_routine: cover property (routine_take);
  c_virtual: cover property (raw_wr);
  c_error_hold: cover property (is_err(sel_raw[0]) ##1 $stable(reading[0]));
endmodule

// ---- test/tw_agent_model.sv ----
// Purpose: behavioural processor agent answering on the thermal wire
// Assumes: wire has a pull-down; host starts every bit driving high
// Notes: tx bits decoded by high versus low time, answers come from resp
`timescale 1ns/1ps
module tw_agent_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host pin
  input wire logic wire_out,
  input wire logic wire_oe_n,
  // answer words a0d0 a0d1 a1d0 a1d1 from the low end
  input wire logic [63:0] resp,
  // agent pulls high, a zero is left to the pull-down
  output logic drv,
  // frame log
  output logic [7:0] frame_cnt,
  output logic [15:0] hdr
);
  int hi, lo, hold, cnt, idle, nbit;
  logic hd_q, oe_q;
  logic [15:0] sh, ans;
  always @(posedge clk) begin
    hd_q <= !wire_oe_n && wire_out;
    oe_q <= wire_oe_n;
    idle = wire_oe_n ? idle + 1 : 0;
    if (!rst_n || idle > 1100) begin
      // resync after reset or an aborted frame
      nbit = 0;
      hi = 0;
      lo = 0;
    end
    if (!rst_n) begin
      frame_cnt <= 8'h00;
      drv <= 1'b0;
    end else if (!wire_oe_n && wire_out && !hd_q) begin
      if (nbit >= 1 && nbit <= 16) sh = {sh[14:0], hi > lo};
      if (nbit == 1) hold = (hi + lo) / 2;
      if (nbit == 16) begin
        hdr <= sh;
        ans = resp[{sh[8], sh[1]} * 16 +: 16];
      end
      nbit++;
      hi = 0;
      lo = 0;
    end else if (wire_oe_n && !oe_q && nbit > 16) begin
      // hold only half a bit so the line is free before the next start
      drv <= ans[32 - nbit];
      cnt = hold;
      if (nbit == 32) begin
        frame_cnt <= frame_cnt + 8'h01;
        nbit = 0;
      end
    end else if (cnt > 0) begin
      cnt--;
    end else begin
      drv <= 1'b0;
    end
    if (!wire_oe_n) begin
      if (wire_out) hi++;
      else lo++;
    end
  end
endmodule

// ---- test/test_tw_host_cfg.sv ----
// Purpose: self-checking bench for the thermal wire host block
// Assumes: one agent model on the wire, routine period shortened to 200
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module test_tw_host_cfg;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, t0, t1, fcnt;
  logic oe_n, wout, drv, win;
  logic [15:0] hdr;
  logic [63:0] resp = 64'h0;
  logic [31:0] vt [9] = '{32'h80ff40fd, 32'h80004001, 32'h90004000,
    32'h80ce0038, 32'h90ce0080, 32'h8080037f, 32'h8080007f,
    32'h80800200, 32'h80ff40fd};
  logic [31:0] ac [4] = '{32'h33043102, 32'h31033101, 32'h32033102,
    32'h10013001};
  logic [15:0] off [3] = '{16'h1006, 16'h0082, 16'h2086};
  int num_errors = 0, cmp_count = 0, cyc = 0, hi_run = 0, gap = 0;
  int nst, min_hi, max_hi, per, p, pct;
  always #5 clk = ~clk;
  // pull-down when nobody drives
  assign win = !oe_n ? wout : drv;
  tw_host_cfg #(.ROUTINE_CYCLES(200)) i_dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wr_en(wr), .reg_rd_en(rd), .reg_wdata(wd),
    .reg_rdata(rdata), .wire_in(win), .wire_out(wout), .wire_oe_n(oe_n),
    .temp_agent0(t0), .temp_agent1(t1));
  tw_agent_model i_agent (.clk(clk), .rst_n(rst_n), .wire_out(wout),
    .wire_oe_n(oe_n), .resp(resp), .drv(drv), .frame_cnt(fcnt), .hdr(hdr));
  task automatic print_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // bit period and host high times, also cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      print_verdict;
    end
  end
  always @(posedge clk) begin
    gap++;
    if (!oe_n && wout) begin
      if (hi_run == 0) begin
        nst++;
        if (nst == 2) per = gap;
        gap = 0;
      end
      hi_run++;
    end else if (hi_run > 0) begin
      if (hi_run < min_hi) min_hi = hi_run;
      if (hi_run > max_hi) max_hi = hi_run;
      hi_run = 0;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // extra cycle lets the registered readings follow the write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wd = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic vraw(input int n, input logic [15:0] w);
    wr_reg(8'(8'h17 + 2 * n), w[15:8]);
    wr_reg(8'(8'h18 + 2 * n), w[7:0]);
  endtask
  task automatic run_round(input logic [7:0] f, input int n);
    logic [7:0] tgt;
    tgt = fcnt + 8'(n);
    nst = 0;
    min_hi = 99999;
    max_hi = 0;
    wr_reg(8'h01, f);
    for (int i = 0; i < 40000 && fcnt !== tgt; i++) @(negedge clk);
    chk({8'h00, fcnt}, {8'h00, tgt});
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    rd_chk(8'h01, 8'h14);
    rd_chk(8'h02, 8'h02);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h04, 8'h00);
    for (int a = 8'h17; a <= 8'h1e; a++) begin
      rd_chk(8'(a), a % 2 ? 8'h80 : 8'h01);
    end
    rd_chk(8'h40, 8'h00);
    wr_reg(8'h20, 8'h55);
    rd_chk(8'h20, 8'h00);
    wr_reg(8'h03, 8'hcc);
    rd_chk(8'h03, 8'hcc);
    wr_reg(8'h17, 8'h12);
    rd_chk(8'h17, 8'h80);
    foreach (vt[k]) begin
      wr_reg(8'h04, vt[k][31:24]);
      vraw(0, vt[k][23:8]);
      chk({8'h00, t0}, {8'h00, vt[k][7:0]});
    end
    vraw(1, 16'hffc0);
    wr_reg(8'h04, 8'h82);
    chk({8'h00, t0}, 16'h00ff);
    wr_reg(8'h04, 8'h84);
    chk({8'h00, t0}, 16'h00fd);
    wr_reg(8'h04, 8'h81);
    rd_chk(8'h20, 8'hff);
    vraw(2, 16'hff80);
    wr_reg(8'h04, 8'h00);
    rd_chk(8'h21, 8'hfe);
    foreach (off[k]) begin
      nst = 0;
      wr_reg(8'h03, off[k][15:8]);
      wr_reg(8'h01, off[k][7:0]);
      repeat (500) @(negedge clk);
      chk(16'(nst), 16'h0000);
    end
    resp = 64'h8003_8000_fec0_ff40;
    wr_reg(8'h03, 8'h10);
    run_round(8'h81, 2);
    wr_reg(8'h01, 8'h00);
    chk(hdr, 16'h3001);
    repeat (1200) @(negedge clk);
    foreach (ac[k]) begin
      wr_reg(8'h03, ac[k][31:24]);
      run_round(8'h86, int'(ac[k][23:16]));
      chk(hdr, ac[k][15:0]);
    end
    rd_chk(8'h01, 8'h84);
    rd_chk(8'h1b, 8'h80);
    rd_chk(8'h1c, 8'h00);
    chk({8'h00, t1}, 16'h00fe);
    chk({8'h00, t0}, 16'h00fd);
    for (int r = 0; r < 4; r++) begin
      p = tw_pkg::BIT_CYC << r;
      pct = r % 2 ? tw_pkg::DUTY_LO_PCT : tw_pkg::DUTY_HI_PCT;
      wr_reg(8'h01, 8'h00);
      wr_reg(8'h02, 8'(r * 16 + (r * 2 + 1) * 2 + r % 2));
      resp[7:0] = 8'(8'h40 + r);
      run_round(8'h82, 1);
      chk(16'(per), 16'(p));
      chk(16'(max_hi), 16'(p * pct / 100 + r * 2 + 1));
      chk(16'(min_hi), 16'(p / 4 + r * 2 + 1));
      // raw word lands near the end of the last bit, after the count
      repeat (p) @(negedge clk);
      rd_chk(8'h18, 8'(8'h40 + r));
    end
    print_verdict;
  end
endmodule
